//--- src/uwa_defs.svh
`ifndef UWA_DEFS_SVH
`define UWA_DEFS_SVH
// ======================================
// word areas
`define UWA_SIMPLE_BASE 14'd0
`define UWA_SIMPLE_LAST 14'd19
`define UWA_INTEL_BASE 14'd2000
`define UWA_INTEL_WORDS 14'd10
`define UWA_INTEL_MIN 7'd10
`define UWA_INTEL_MAX 7'd95
`define UWA_BM_BASE 14'd1500
`define UWA_BM_WORDS 14'd25
`define UWA_BM_MAX 7'd15
`define UWA_BUILTIN_IN 14'd2960
`define UWA_BUILTIN_OUT 14'd2961
`define UWA_DM_INTEL_BASE 15'd20000
`define UWA_DM_BM_BASE 15'd30000
`define UWA_DM_WORDS 15'd100
// ======================================
// register word offsets
`define UWA_REG_CTRL 4'h0
`define UWA_REG_STATUS 4'h1
`define UWA_REG_SCAN 4'h2
`define UWA_REG_QUERY 4'h3
`define UWA_REG_RESULT 4'h4
`define UWA_REG_INTEL_RST 4'h8
`define UWA_REG_INTEL_INIT 4'h9
`define UWA_REG_BM_RST 4'ha
`define UWA_REG_BM_INIT 4'hb
`define UWA_REG_BAD 32'hdeadbeef
// ======================================
// timing: initialization length of one unit, cycles
`define UWA_INIT_CYCLES 8'd16
`endif

//--- src/uwa_pkg.sv
package uwa_pkg;
  // unit classes reported by the backplane probe
  typedef enum logic [1:0] {
    UWA_NONE = 2'b00,
    UWA_SIMPLE = 2'b01,
    UWA_INTEL = 2'b10,
    UWA_BUSM = 2'b11
  } uwa_kind_t;
  // one query answer
  typedef struct packed {
    logic valid;
    logic [13:0] cio_base;
    logic [14:0] dm_base;
  } uwa_alloc_t;
  // scan sequencer
  typedef enum logic [1:0] {
    UWA_ST_IDLE = 2'b00,
    UWA_ST_REFRESH = 2'b01,
    UWA_ST_DONE = 2'b10
  } uwa_state_t;
endpackage

//--- src/uwa_top.sv
// Notes on behaviour
// (R1) intelligent unit gets ten words at 2000+10n
// (R2) intelligent numbers 10..95 only, software's duty
// (R3) slot allocation skips intelligent and bus-master units
// (R4) bus-master gets 25 words at 1500+25n
// (R5) duplicate bus-master numbers raise no error
// (R6) simple units get 1,2,4 words in 0..19
// (R7) refresh every unit once per scan
// (R8) intelligent units get 100 data words each
// (R9) bus-master units get 100 data words each
// (R10) data transfers: restart, per cycle, on demand
// (R11) intelligent restart bit reinitializes the unit
// (R12) intelligent init flag high while initializing
// (R13) no refresh of initializing intelligent unit
// (R14) bus-master restart bit reinitializes the unit
// (R15) bus-master init flag high while initializing
// (R16) no refresh of initializing bus-master unit
// (R17) program restarts unit after changing settings
// (R18) bus-master data transfers in both directions
// (R19) built-in inputs 2960, outputs 2961
// (R20) init flag clears itself, refresh resumes
`timescale 1ns/1ns
`default_nettype none
`include "uwa_defs.svh"
module uwa_top import uwa_pkg::*; #(
  parameter int SLOTS = 10,
  parameter int INIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // backplane probe: per slot kind, word need (0=1,1=2,2=4) and unit number
  input wire logic [2*SLOTS-1:0] slot_kind,
  input wire logic [2*SLOTS-1:0] slot_size,
  input wire logic [7*SLOTS-1:0] slot_unit,
  // per-slot init done from unit
  input wire logic [SLOTS-1:0] unit_init_done,
  // per-slot refresh strobe and cyclic word base
  output logic [SLOTS-1:0] refresh_strobe,
  output logic [14*SLOTS-1:0] slot_cio_base,
  output logic [SLOTS-1:0] unit_init_req,
  output logic [13:0] builtin_in_word,
  output logic [13:0] builtin_out_word,
  output logic scan_done
);

  // ======================================
  // address helpers
  // intelligent cyclic base from unit number
  function automatic logic [13:0] intel_cio(input logic [6:0] n);
    intel_cio = 14'(`UWA_INTEL_BASE + `UWA_INTEL_WORDS * 14'(n)); // R1
  endfunction
  // bus-master cyclic base
  function automatic logic [13:0] bm_cio(input logic [6:0] n);
    bm_cio = 14'(`UWA_BM_BASE + `UWA_BM_WORDS * 14'(n)); // R4
  endfunction
  // data-memory base; intelligent numbers start at 10 so 20000+100n gives 21000
  function automatic logic [14:0] dm_base(input logic bm, input logic [6:0] n);
    dm_base = bm ? 15'(`UWA_DM_BM_BASE + `UWA_DM_WORDS * 15'(n)) // R9
                 : 15'(`UWA_DM_INTEL_BASE + `UWA_DM_WORDS * 15'(n)); // R8
  endfunction

  // ======================================
  // pin synchronisers
  logic [2*SLOTS-1:0] kind_s1_r, kind_r;
  logic [2*SLOTS-1:0] size_s1_r, size_r;
  logic [7*SLOTS-1:0] unit_s1_r, unit_r;
  logic [SLOTS-1:0] done_s1_r, done_r;
  // two flops per incoming pin group
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kind_s1_r <= '0;
      kind_r <= '0;
      size_s1_r <= '0;
      size_r <= '0;
      unit_s1_r <= '0;
      unit_r <= '0;
      done_s1_r <= '0;
      done_r <= '0;
    end else begin
      kind_s1_r <= slot_kind;
      kind_r <= kind_s1_r;
      size_s1_r <= slot_size;
      size_r <= size_s1_r;
      unit_s1_r <= slot_unit;
      unit_r <= unit_s1_r;
      done_s1_r <= unit_init_done;
      done_r <= done_s1_r;
    end
  end

  // ======================================
  // allocation (combinational over slots)
  logic [14*SLOTS-1:0] cio_nxt;
  logic [SLOTS-1:0] simple_ok_nxt;
  logic [SLOTS-1:0] is_intel, is_bm;
  always_comb begin
    logic [13:0] next_word;
    logic [2:0] need;
    next_word = `UWA_SIMPLE_BASE;
    need = 3'd0;
    cio_nxt = '0;
    simple_ok_nxt = '0;
    for (int i = 0; i < SLOTS; i++) begin
      is_intel[i] = uwa_kind_t'(kind_r[2*i +: 2]) == UWA_INTEL;
      is_bm[i] = uwa_kind_t'(kind_r[2*i +: 2]) == UWA_BUSM;
      // other kinds are skipped, so they never move the simple pointer
      if (uwa_kind_t'(kind_r[2*i +: 2]) == UWA_SIMPLE) begin // R3
        need = (size_r[2*i +: 2] == 2'd0) ? 3'd1 : (size_r[2*i +: 2] == 2'd1) ? 3'd2 : 3'd4; // R6
        if (next_word + 14'(need) <= `UWA_SIMPLE_LAST + 14'd1) begin // R6
          cio_nxt[14*i +: 14] = next_word;
          simple_ok_nxt[i] = 1'b1;
          next_word = 14'(next_word + 14'(need));
        end
      end else if (is_intel[i]) begin
        cio_nxt[14*i +: 14] = intel_cio(unit_r[7*i +: 7]); // R1
      end else if (is_bm[i]) begin
        // shared numbers simply share words; nothing is flagged
        cio_nxt[14*i +: 14] = bm_cio(unit_r[7*i +: 7]); // R4 R5
      end
    end
  end

  // latched map drives the cyclic base output
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot_cio_base <= '0;
    end else begin
      slot_cio_base <= cio_nxt;
    end
  end

  // ======================================
  // software registers
  logic scan_go;
  logic [15:0] scan_count_r;
  logic [6:0] query_r;
  logic query_bm_r;
  logic [95:0] intel_init_r; // one per number 0..95
  logic [15:0] bm_init_r;
  logic [95:0] intel_rst_pulse;
  logic [15:0] bm_rst_pulse;
  logic [7:0] init_cnt_r [SLOTS];
  logic [SLOTS-1:0] init_busy_r;
  assign avs_waitrequest = 1'b0;
  assign scan_go = avs_write && avs_address == `UWA_REG_SCAN;
  assign builtin_in_word = `UWA_BUILTIN_IN; // R19
  assign builtin_out_word = `UWA_BUILTIN_OUT; // R19

  // restart bits are write-one pulses per unit number
  always_comb begin
    intel_rst_pulse = '0;
    bm_rst_pulse = '0;
    if (avs_write && avs_address == `UWA_REG_INTEL_RST && avs_writedata[6:0] <= `UWA_INTEL_MAX) begin
      intel_rst_pulse[avs_writedata[6:0]] = 1'b1; // R11
    end
    if (avs_write && avs_address == `UWA_REG_BM_RST && avs_writedata[6:0] <= `UWA_BM_MAX) begin
      bm_rst_pulse[avs_writedata[3:0]] = 1'b1; // R14
    end
  end

  // query registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      query_r <= '0;
      query_bm_r <= 1'b0;
    end else if (avs_write && avs_address == `UWA_REG_QUERY) begin
      query_r <= avs_writedata[6:0];
      query_bm_r <= avs_writedata[8];
    end
  end

  // ======================================
  // per-slot initialization
  // power-on starts every unit initializing; restart re-arms it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      init_busy_r <= '1; // R11 R14
      for (int i = 0; i < SLOTS; i++) begin
        init_cnt_r[i] <= 8'd0;
      end
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        if ((is_intel[i] && intel_rst_pulse[unit_r[7*i +: 7]]) ||
            (is_bm[i] && bm_rst_pulse[unit_r[7*i +: 4]])) begin
          init_busy_r[i] <= 1'b1; // R11 R14
          init_cnt_r[i] <= 8'd0;
        end else if (init_busy_r[i]) begin
          if (done_r[i] || init_cnt_r[i] == 8'(INIT_CYCLES - 1)) begin
            init_busy_r[i] <= 1'b0; // R20
          end else begin
            init_cnt_r[i] <= 8'(init_cnt_r[i] + 8'd1);
          end
        end
      end
    end
  end
  assign unit_init_req = init_busy_r;

  // flags by unit number gathered from slots
  always_comb begin
    intel_init_r = '0;
    bm_init_r = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (is_intel[i] && init_busy_r[i]) begin
        intel_init_r[unit_r[7*i +: 7]] = 1'b1; // R12
      end
      if (is_bm[i] && init_busy_r[i]) begin
        bm_init_r[unit_r[7*i +: 4]] = 1'b1; // R15
      end
    end
  end

  // ======================================
  // scan refresh sequencer
  uwa_state_t state_r;
  // one scan request walks IDLE -> REFRESH -> DONE -> IDLE
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= UWA_ST_IDLE;
    end else begin
      case (state_r)
        UWA_ST_IDLE: begin
          if (scan_go) begin
            state_r <= UWA_ST_REFRESH;
          end
        end
        UWA_ST_REFRESH: state_r <= UWA_ST_DONE;
        UWA_ST_DONE: state_r <= UWA_ST_IDLE;
        default: state_r <= UWA_ST_IDLE;
      endcase
    end
  end

  // strobe every mapped, ready unit once per scan
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refresh_strobe <= '0;
      scan_done <= 1'b0;
      scan_count_r <= '0;
    end else begin
      scan_done <= state_r == UWA_ST_DONE;
      for (int i = 0; i < SLOTS; i++) begin
        refresh_strobe[i] <= state_r == UWA_ST_REFRESH && // R7
                             (simple_ok_nxt[i] || is_intel[i] || is_bm[i]) &&
                             !init_busy_r[i]; // R13 R16 R20
      end
      if (state_r == UWA_ST_DONE) begin
        scan_count_r <= 16'(scan_count_r + 16'd1);
      end
    end
  end

  // ======================================
  // read mux, answered in the cycle of the request
  always_comb begin
    uwa_alloc_t q;
    q.valid = query_bm_r ? (query_r <= `UWA_BM_MAX)
                         : (query_r >= `UWA_INTEL_MIN && query_r <= `UWA_INTEL_MAX);
    q.cio_base = query_bm_r ? bm_cio(query_r) : intel_cio(query_r);
    q.dm_base = dm_base(query_bm_r, query_r); // R8 R9 R10 R18
    avs_readdata = '0;
    if (avs_read) begin
      case (avs_address)
        `UWA_REG_CTRL: avs_readdata = 32'(SLOTS);
        `UWA_REG_STATUS: avs_readdata = {30'd0, state_r};
        `UWA_REG_SCAN: avs_readdata = {16'd0, scan_count_r};
        `UWA_REG_QUERY: avs_readdata = {23'd0, query_bm_r, 1'b0, query_r};
        `UWA_REG_RESULT: avs_readdata = {2'd0, q};
        `UWA_REG_INTEL_INIT: avs_readdata = {intel_init_r[95:64] == 32'd0, 31'(|intel_init_r)};
        `UWA_REG_BM_INIT: avs_readdata = {16'd0, bm_init_r};
        default: avs_readdata = `UWA_REG_BAD;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- test/uwa_units.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================
// mounted expansion units on the backplane
module uwa_units import uwa_pkg::*; #(
  parameter int SLOTS = 5,
  parameter int DONE_DELAY = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [SLOTS-1:0] unit_init_req,
  input wire logic [SLOTS-1:0] slow,
  output logic [2*SLOTS-1:0] slot_kind,
  output logic [2*SLOTS-1:0] slot_size,
  output logic [7*SLOTS-1:0] slot_unit,
  output logic [SLOTS-1:0] unit_init_done
);
  logic [7:0] cnt_r [SLOTS]; // cycles spent initializing
  // rack: simple(2 words), intel 10, simple(1 word), two bus-masters both 15
  assign slot_kind = {UWA_BUSM, UWA_BUSM, UWA_SIMPLE, UWA_INTEL, UWA_SIMPLE};
  assign slot_size = 10'h001;
  assign slot_unit = {7'h0f, 7'h0f, 7'h00, 7'h0a, 7'h00};
  // a fast unit reports done after a few cycles, a slow one never does
  always_ff @(posedge clk or negedge resetn) begin
    for (int i = 0; i < SLOTS; i++) begin
      if (!resetn) begin
        cnt_r[i] <= 8'h00;
        unit_init_done[i] <= 1'b0;
      end else begin
        cnt_r[i] <= unit_init_req[i] ? cnt_r[i] + 8'h01 : 8'h00;
        unit_init_done[i] <= unit_init_req[i] && !slow[i] && cnt_r[i] >= 8'(DONE_DELAY);
      end
    end
  end
endmodule
`default_nettype wire

//--- test/uwa_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================
// port checker of the allocator
module uwa_top_sva #(
  parameter int SLOTS = 10,
  parameter int INIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [2*SLOTS-1:0] slot_kind,
  input wire logic [7*SLOTS-1:0] slot_unit,
  input wire logic [SLOTS-1:0] refresh_strobe,
  input wire logic [14*SLOTS-1:0] slot_cio_base,
  input wire logic [SLOTS-1:0] unit_init_req,
  input wire logic [13:0] builtin_in_word,
  input wire logic [13:0] builtin_out_word,
  input wire logic scan_done
);
  localparam int INIT_MAX = INIT_CYCLES + 4; // init length plus sync slack
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_BUILTIN: assert property (builtin_in_word == 14'hb90 && builtin_out_word == 14'hb91) else $error("builtin word");
  AST_SCAN_DONE: assert property (avs_write && avs_address == 4'h2 |-> ##3 scan_done) else $error("scan end");
  // per-slot checks
  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    wire [1:0] k = slot_kind[2*i+:2];
    wire [6:0] u = slot_unit[7*i+:7];
    wire [13:0] b = slot_cio_base[14*i+:14];
    AST_INTEL_RESTART: assert property (avs_write && avs_address == 4'h8 && k == 2'h2 && avs_writedata == {25'h0, u}
      && u >= 7'h0a && u <= 7'h5f |=> unit_init_req[i]) else $error("intel restart");
    AST_BM_RESTART: assert property (avs_write && avs_address == 4'ha && k == 2'h3 && avs_writedata == {25'h0, u}
      && u <= 7'h0f |=> unit_init_req[i]) else $error("bm restart");
    AST_INIT_NO_REFRESH: assert property (unit_init_req[i] && $past(unit_init_req[i]) |-> !refresh_strobe[i])
      else $error("refresh while init");
    AST_INIT_BOUND: assert property ($rose(unit_init_req[i]) |-> ##[1:INIT_MAX] !unit_init_req[i]) else $error("init stuck");
    AST_STROBE_PULSE: assert property (refresh_strobe[i] |=> !refresh_strobe[i]) else $error("strobe width");
    AST_BASE_INTEL: assert property (k == 2'h2 && $past(resetn, 4) && $past(k, 4) == k && $past(u, 4) == u
      |-> b == 14'h7d0 + 14'h00a * u) else $error("intel base");
    AST_BASE_BM: assert property (k == 2'h3 && $past(resetn, 4) && $past(k, 4) == k && $past(u, 4) == u
      |-> b == 14'h5dc + 14'h019 * u) else $error("bm base");
  end
  CV_SCAN: cover property (scan_done);
  CV_RESTART: cover property (avs_write && avs_address == 4'h8);
  CV_BM: cover property (avs_write && avs_address == 4'ha);
endmodule
bind uwa_top uwa_top_sva #(.SLOTS(SLOTS), .INIT_CYCLES(INIT_CYCLES)) i_sva (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata), .slot_kind(slot_kind),
  .slot_unit(slot_unit), .refresh_strobe(refresh_strobe), .slot_cio_base(slot_cio_base),
  .unit_init_req(unit_init_req), .builtin_in_word(builtin_in_word), .builtin_out_word(builtin_out_word),
  .scan_done(scan_done));
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================
// allocator bench
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, scan_done;
  logic [9:0] kind, size;
  logic [34:0] unum;
  logic [4:0] done, strobe, ireq, seen;
  logic [4:0] slow = 5'h1f; // units slow unless a test says otherwise
  logic [69:0] base;
  logic [13:0] bin, bout;
  int fail_count = 0;
  int check_count = 0;
  // query word, then valid, cyclic base and data-memory base as the result register packs them
  logic [57:0] qtab [4] = '{{16'h000a, 12'h000, 1'b1, 14'h834, 15'h5208},
    {16'h005f, 12'h000, 1'b1, 14'hb86, 15'h733c},
    {16'h0100, 12'h000, 1'b1, 14'h5dc, 15'h7530},
    {16'h010f, 12'h000, 1'b1, 14'h753, 15'h7b0c}};
  always #50 clk = ~clk;
  uwa_top #(.SLOTS(5), .INIT_CYCLES(12)) i_dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .slot_kind(kind), .slot_size(size), .slot_unit(unum),
    .unit_init_done(done), .refresh_strobe(strobe), .slot_cio_base(base), .unit_init_req(ireq),
    .builtin_in_word(bin), .builtin_out_word(bout), .scan_done(scan_done));
  uwa_units #(.SLOTS(5)) i_units (.clk(clk), .resetn(resetn), .unit_init_req(ireq), .slow(slow),
    .slot_kind(kind), .slot_size(size), .slot_unit(unum), .unit_init_done(done));
  // ======================================
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  // start a scan and gather the strobes it gives
  task automatic scan;
    int n;
    seen = 5'h0;
    n = 0;
    bus(1'b1, 4'h2, 32'h0);
    while (scan_done !== 1'b1 && n < 10) begin
      @(negedge clk);
      seen = seen | strobe;
      n++;
    end
    @(posedge clk);
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ======================================
  // scenarios
  task automatic t_alloc;
    repeat (30) @(posedge clk);
    check(ireq, 5'h00);
    check({bin, bout}, {14'hb90, 14'hb91});
    check(base, {14'h753, 14'h753, 14'h002, 14'h834, 14'h000});
    scan();
    check(seen, 5'h1f);
    $display("alloc test done");
  endtask
  task automatic t_intel;
    bus(1'b1, 4'h8, 32'h9);
    check(ireq, 5'h00);
    bus(1'b1, 4'h8, 32'ha);
    check(ireq, 5'h02);
    bus(1'b0, 4'h9, 32'h0);
    check(rd[0], 1'b1);
    scan();
    check(seen, 5'h1d);
    repeat (16) @(posedge clk);
    check(ireq, 5'h00);
    scan();
    check(seen, 5'h1f);
    $display("intel test done");
  endtask
  task automatic t_bm;
    slow <= 5'h00;
    bus(1'b1, 4'ha, 32'hf);
    check(ireq, 5'h18);
    bus(1'b0, 4'hb, 32'h0);
    check(rd, 32'h8000);
    scan();
    check(seen, 5'h07);
    repeat (16) @(posedge clk);
    scan();
    check(seen, 5'h1f);
    $display("bm test done");
  endtask
  task automatic t_query;
    foreach (qtab[i]) begin
      bus(1'b1, 4'h3, {16'h0, qtab[i][57:42]});
      bus(1'b0, 4'h4, 32'h0);
      check(rd, {2'h0, qtab[i][29:0]});
    end
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h5);
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h5);
    bus(1'b0, 4'hf, 32'h0);
    check(rd, 32'hdeadbeef);
    $display("query test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    check(ireq, 5'h1f);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_alloc();
    t_intel();
    t_bm();
    t_query();
    results();
  end
  initial begin
    #(3000 * 100);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
